//--- sbc_pkg.sv
// Package for the statistics batch and cycle control block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package sbc_pkg;

	// Register byte offsets
	localparam logic [7:0] SBC_REG_CTRL     = 8'h00;
	localparam logic [7:0] SBC_REG_ITEMS    = 8'h04;
	localparam logic [7:0] SBC_REG_BPULSES  = 8'h08;
	localparam logic [7:0] SBC_REG_BTIME    = 8'h0c;
	localparam logic [7:0] SBC_REG_SUBPULSE = 8'h10;
	localparam logic [7:0] SBC_REG_RATEDIV  = 8'h14;
	localparam logic [7:0] SBC_REG_PSTIME   = 8'h18;
	localparam logic [7:0] SBC_REG_CMD      = 8'h1c;
	localparam logic [7:0] SBC_REG_STATUS   = 8'h20;
	localparam logic [7:0] SBC_REG_IRQ_STAT = 8'h24;
	localparam logic [7:0] SBC_REG_IRQ_MASK = 8'h28;
	localparam logic [7:0] SBC_REG_ITEMLIST = 8'h2c;

	// Control register fields
	localparam int SBC_CTRL_AUTORANGE = 0;
	localparam int SBC_CTRL_AUTORESTART = 1;
	localparam int SBC_CTRL_VZOOM_LSB = 4;
	localparam int SBC_CTRL_HZOOM_LSB = 8;
	localparam int SBC_ZOOM_W = 3;

	// Command register bits (write one to issue)
	localparam int SBC_CMD_STAT_BEGIN = 0;
	localparam int SBC_CMD_STAT_END = 1;
	localparam int SBC_CMD_PS_BEGIN = 2;
	localparam int SBC_CMD_PS_END = 3;
	localparam int SBC_CMD_TUNE_ERASE = 4;

	// Interrupt / event bits
	localparam int SBC_EV_W = 4;
	localparam int SBC_EV_ARG_ERR = 0;
	localparam int SBC_EV_BATCH_DONE = 1;
	localparam int SBC_EV_CYCLE_DONE = 2;
	localparam int SBC_EV_LIST_ERR = 3;

	// Statistics items, canonical order is bit order
	localparam int SBC_ITEMS = 10;
	localparam int SBC_ITEMS_SHOWN = 6;
	localparam int SBC_ITEM_TOKENS_MAX = 10;
	localparam logic [9:0] SBC_ITEMS_RST = 10'h00f;

	// Ranges and defaults
	localparam logic [16:0] SBC_BPULSE_MIN = 17'h00002;
	localparam logic [16:0] SBC_BPULSE_MAX = 17'h1869f;
	localparam logic [16:0] SBC_BPULSE_RST = 17'h00064;
	localparam logic [16:0] SBC_SUB_MIN = 17'h00001;
	localparam logic [16:0] SBC_SUB_MAX = 17'h1869f;
	localparam logic [16:0] SBC_SUB_RST = 17'h00001;
	localparam logic [16:0] SBC_SECS_MIN = 17'h00001;
	localparam logic [16:0] SBC_SECS_MAX = 17'h15180;
	localparam logic [16:0] SBC_SECS_RST = 17'h0003c;
	// Tick divider: 1 -> 10/s, 2 -> 5/s, 5 -> 2/s, 10 -> 1/s
	localparam logic [3:0] SBC_DIV_RST = 4'h1;
	localparam int SBC_TICK_HZ = 10;
	localparam int SBC_CLK_HZ = 100_000_000;
	localparam int SBC_TICK_CYCLES = SBC_CLK_HZ / SBC_TICK_HZ;

	// Zoom codes
	typedef enum logic [2:0] {
		SBC_ZOOM_AUTO,
		SBC_ZOOM_X1,
		SBC_ZOOM_X2,
		SBC_ZOOM_X5,
		SBC_ZOOM_X10,
		SBC_ZOOM_X20
	} sbc_zoom_type;

	typedef struct packed {
		logic [7:0]  adr;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} sbc_wb_req_type;

	typedef struct packed {
		logic        stat_mode;
		logic        ps_mode;
		logic        energy_mode;
		logic        pulse_sensor;
		logic        quad_sensor;
		logic        range_sensor;
	} sbc_env_type;

endpackage : sbc_pkg

//--- sbc_ctrl.sv
// Statistics batch, position stability cycle and tune chart control.
// Assumes a classic Wishbone master and a measurement engine in another clock domain.
`timescale 1ns/1ps

module sbc_ctrl
	import sbc_pkg::*;
#(
	parameter int TICK_CYCLES = SBC_TICK_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire sbc_env_type env_i,
	input  wire logic        pulse_i,
	output logic             auto_range_o,
	output logic      [9:0]  items_shown_o,
	output logic             batch_run_o,
	output logic             sample_o,
	output logic             cycle_run_o,
	output sbc_zoom_type     vzoom_o,
	output sbc_zoom_type     hzoom_o,
	output logic             chart_erase_o,
	output logic             irq_o
);

	// Pins from the engine come from another domain
	sbc_env_type env_s1_q, env_q;
	logic        pulse_s1_q, pulse_s2_q, pulse_s3_q;

	sbc_wb_req_type req;
	logic  acc, wr, ack_q;
	logic  [31:0] rd_d, rd_q;

	logic        autorange_q, autorestart_q;
	sbc_zoom_type vzoom_q, hzoom_q;
	logic [9:0]  items_pend_q, items_act_q, items_shown;
	logic [16:0] bpulse_pend_q, bpulse_act_q;
	logic [16:0] btime_pend_q, btime_act_q;
	logic [16:0] sub_pend_q, sub_act_q;
	logic [3:0]  div_pend_q, div_act_q;
	logic [16:0] ps_pend_q, ps_act_q;
	logic [SBC_EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
	logic        arg_err, list_err;

	// Wide enough for a full day of ticks
	localparam int CNT_W = $clog2(int'(SBC_SECS_MAX) * SBC_TICK_HZ + 1);

	logic        batch_q, cycle_q, batch_end, cycle_end, pulse_mode;
	logic [16:0] subcnt_q;
	logic [CNT_W-1:0] bcnt_q, ps_cnt_q, batch_len, cycle_len;
	logic [31:0] tick_cnt_q;
	logic [3:0]  div_cnt_q;
	logic        tick, pulse_rise, sample;
	logic [4:0]  cmd;
	logic        erase_q;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			env_s1_q   <= '0;
			env_q      <= '0;
			pulse_s1_q <= 1'b0;
			pulse_s2_q <= 1'b0;
			pulse_s3_q <= 1'b0;
		end else begin
			env_s1_q   <= env_i;
			env_q      <= env_s1_q;
			pulse_s1_q <= pulse_i;
			pulse_s2_q <= pulse_s1_q;
			pulse_s3_q <= pulse_s2_q;
		end
	end
	assign pulse_rise = pulse_s2_q & ~pulse_s3_q;

	// Bus decode; ack one cycle after request, dropped next cycle
	assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
	assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr  = acc & req.we & (&req.sel);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			rd_q  <= '0;
		end else begin
			ack_q <= acc;
			rd_q  <= rd_d;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_q;

	function automatic logic zoom_ok(input logic [31:0] v, input logic allow_auto);
		zoom_ok = (v[2:0] <= 3'(SBC_ZOOM_X20)) && (v[31:3] == '0) &&
			(allow_auto || v[2:0] != 3'(SBC_ZOOM_AUTO));
	endfunction : zoom_ok

	function automatic logic in_range(input logic [31:0] v, input logic [16:0] lo, input logic [16:0] hi);
		in_range = (v[31:17] == '0) && (v[16:0] >= lo) && (v[16:0] <= hi);
	endfunction : in_range

	function automatic logic div_ok(input logic [31:0] v);
		div_ok = (v == 32'h1) || (v == 32'h2) || (v == 32'h5) || (v == 32'ha);
	endfunction : div_ok

	always_comb begin
		arg_err = 1'b0;
		if (wr) begin
			case (req.adr)
				SBC_REG_CTRL:     arg_err = !zoom_ok({29'h0, req.dat[SBC_CTRL_VZOOM_LSB +: SBC_ZOOM_W]}, 1'b1) ||
					!zoom_ok({29'h0, req.dat[SBC_CTRL_HZOOM_LSB +: SBC_ZOOM_W]}, 1'b0);
				SBC_REG_BPULSES:  arg_err = !in_range(req.dat, SBC_BPULSE_MIN, SBC_BPULSE_MAX);
				SBC_REG_BTIME:    arg_err = !in_range(req.dat, SBC_SECS_MIN, SBC_SECS_MAX);
				SBC_REG_SUBPULSE: arg_err = !in_range(req.dat, SBC_SUB_MIN, SBC_SUB_MAX);
				SBC_REG_RATEDIV:  arg_err = !div_ok(req.dat);
				SBC_REG_PSTIME:   arg_err = !in_range(req.dat, SBC_SECS_MIN, SBC_SECS_MAX);
				default:          arg_err = 1'b0;
			endcase
		end
	end

	// token count from the written list word
	always_comb begin
		list_err = 1'b0;
		if (wr && req.adr == SBC_REG_ITEMS)
			list_err = (req.dat[31:16] > 16'(SBC_ITEM_TOKENS_MAX)) || (req.dat[SBC_ITEMS-1:0] == '0);
	end

	assign cmd = (wr && req.adr == SBC_REG_CMD) ? req.dat[4:0] : 5'h0;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			autorange_q   <= 1'b0;
			autorestart_q <= 1'b0;
			vzoom_q       <= SBC_ZOOM_AUTO;
			hzoom_q       <= SBC_ZOOM_X1;
		end else if (wr && req.adr == SBC_REG_CTRL && !arg_err) begin
			autorange_q   <= req.dat[SBC_CTRL_AUTORANGE];
			autorestart_q <= req.dat[SBC_CTRL_AUTORESTART];
			vzoom_q       <= sbc_zoom_type'(req.dat[SBC_CTRL_VZOOM_LSB +: SBC_ZOOM_W]);
			hzoom_q       <= sbc_zoom_type'(req.dat[SBC_CTRL_HZOOM_LSB +: SBC_ZOOM_W]);
		end
	end
	assign auto_range_o = autorange_q & env_q.range_sensor;

	// pending settings, kept on bad argument
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			items_pend_q  <= SBC_ITEMS_RST;
			bpulse_pend_q <= SBC_BPULSE_RST;
			btime_pend_q  <= SBC_SECS_RST;
			sub_pend_q    <= SBC_SUB_RST;
			div_pend_q    <= SBC_DIV_RST;
			ps_pend_q     <= SBC_SECS_RST;
		end else if (wr && !arg_err && !list_err) begin
			case (req.adr)
				SBC_REG_ITEMS:    items_pend_q  <= req.dat[SBC_ITEMS-1:0];
				SBC_REG_BPULSES:  bpulse_pend_q <= req.dat[16:0];
				SBC_REG_BTIME:    btime_pend_q  <= req.dat[16:0];
				SBC_REG_SUBPULSE: sub_pend_q    <= req.dat[16:0];
				SBC_REG_RATEDIV:  div_pend_q    <= req.dat[3:0];
				SBC_REG_PSTIME:   ps_pend_q     <= req.dat[16:0];
				default:          ;
			endcase
		end
	end

	// batch settings latched at batch end or when idle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			items_act_q  <= SBC_ITEMS_RST;
			bpulse_act_q <= SBC_BPULSE_RST;
			btime_act_q  <= SBC_SECS_RST;
			sub_act_q    <= SBC_SUB_RST;
			div_act_q    <= SBC_DIV_RST;
		end else if (batch_end || !batch_q) begin
			items_act_q  <= items_pend_q;
			bpulse_act_q <= bpulse_pend_q;
			btime_act_q  <= btime_pend_q;
			sub_act_q    <= sub_pend_q;
			div_act_q    <= div_pend_q;
		end
	end

	// cycle time latched at cycle end or when idle
	always_ff @(posedge mclk) begin
		if (!rstn)
			ps_act_q <= SBC_SECS_RST;
		else if (cycle_end || !cycle_q)
			ps_act_q <= ps_pend_q;
	end

	// first six selected items in canonical order
	always_comb begin
		int n;
		n = 0;
		items_shown = '0;
		for (int i = 0; i < SBC_ITEMS; i++) begin
			if (items_act_q[i] && n < SBC_ITEMS_SHOWN) begin
				items_shown[i] = 1'b1;
				n = n + 1;
			end
		end
	end
	assign items_shown_o = items_shown;

	// fixed ten per second tick, then divider
	always_ff @(posedge mclk) begin
		if (!rstn)
			tick_cnt_q <= '0;
		else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 32'h1;
	end
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

	// divided rate held at zero while no batch runs; a begin command mid-batch does not clear it
	always_ff @(posedge mclk) begin
		if (!rstn)
			div_cnt_q <= '0;
		else if (!batch_q)
			div_cnt_q <= '0;
		else if (tick)
			div_cnt_q <= (div_cnt_q + 4'h1 >= div_act_q) ? 4'h0 : div_cnt_q + 4'h1;
	end

	// subsample pulses, one kept per N
	always_ff @(posedge mclk) begin
		if (!rstn)
			subcnt_q <= '0;
		else if (!batch_q)
			subcnt_q <= '0;
		else if (pulse_rise && pulse_mode)
			subcnt_q <= (subcnt_q + 17'h1 >= sub_act_q) ? 17'h0 : subcnt_q + 17'h1;
	end

	// Pulse counting for pulse sensors and energy mode
	assign pulse_mode = env_q.pulse_sensor | env_q.energy_mode;

	always_comb begin
		if (pulse_mode)
			sample = batch_q && pulse_rise && (subcnt_q + 17'h1 >= sub_act_q);
		else
			sample = batch_q && tick && (div_cnt_q + 4'h1 >= div_act_q);
	end
	assign sample_o = sample;

	always_ff @(posedge mclk) begin
		if (!rstn)
			bcnt_q <= '0;
		// Auto restart needs a fresh count at each batch end
		else if (!batch_q || cmd[SBC_CMD_STAT_BEGIN] || batch_end)
			bcnt_q <= '0;
		else if (sample)
			bcnt_q <= bcnt_q + CNT_W'(1'b1);
	end

	// Divider is 1, 2, 5 or 10, so the quotient is exact
	assign batch_len = pulse_mode ? CNT_W'(bpulse_act_q)
		: CNT_W'(CNT_W'(btime_act_q) * CNT_W'(SBC_TICK_HZ) / CNT_W'(div_act_q));
	assign batch_end = sample && (bcnt_q + CNT_W'(1'b1) >= batch_len);

	always_ff @(posedge mclk) begin
		if (!rstn)
			batch_q <= 1'b0;
		else if (cmd[SBC_CMD_STAT_BEGIN] && env_q.stat_mode)
			batch_q <= 1'b1;
		else if (cmd[SBC_CMD_STAT_END] && env_q.stat_mode && batch_q)
			batch_q <= 1'b0;
		else if (batch_end)
			batch_q <= autorestart_q;
		else if (!env_q.stat_mode)
			batch_q <= 1'b0;
	end
	assign batch_run_o = batch_q;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cycle_q  <= 1'b0;
			ps_cnt_q <= '0;
		end else if (cmd[SBC_CMD_PS_BEGIN] && env_q.ps_mode && env_q.quad_sensor) begin
			cycle_q  <= 1'b1;
			ps_cnt_q <= '0;
		end else if (cmd[SBC_CMD_PS_END] && env_q.ps_mode && cycle_q) begin
			cycle_q  <= 1'b0;
		end else if (cycle_end) begin
			ps_cnt_q <= '0;
		end else if (cycle_q && tick) begin
			ps_cnt_q <= ps_cnt_q + CNT_W'(1'b1);
		end
	end
	assign cycle_len   = CNT_W'(ps_act_q) * CNT_W'(SBC_TICK_HZ);
	assign cycle_end   = cycle_q && (ps_cnt_q >= cycle_len);
	assign cycle_run_o = cycle_q;

	always_ff @(posedge mclk) begin
		if (!rstn)
			erase_q <= 1'b0;
		else
			erase_q <= cmd[SBC_CMD_TUNE_ERASE];
	end
	assign chart_erase_o = erase_q;
	assign vzoom_o = vzoom_q;
	assign hzoom_o = hzoom_q;

	// Sticky events, set beats write-one-clear
	always_comb begin
		ev_set = '0;
		ev_set[SBC_EV_ARG_ERR]    = arg_err;
		ev_set[SBC_EV_BATCH_DONE] = batch_end;
		ev_set[SBC_EV_CYCLE_DONE] = cycle_end;
		ev_set[SBC_EV_LIST_ERR]   = list_err;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ev_stat_q <= '0;
			ev_mask_q <= '0;
		end else begin
			if (wr && req.adr == SBC_REG_IRQ_STAT)
				ev_stat_q <= (ev_stat_q & ~req.dat[SBC_EV_W-1:0]) | ev_set;
			else
				ev_stat_q <= ev_stat_q | ev_set;
			if (wr && req.adr == SBC_REG_IRQ_MASK)
				ev_mask_q <= req.dat[SBC_EV_W-1:0];
		end
	end
	assign irq_o = |(ev_stat_q & ev_mask_q);

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_d = '0;
		if (acc && !req.we) begin
			case (req.adr)
				SBC_REG_CTRL:     rd_d = {20'h0, 1'b0, 3'(hzoom_q), 1'b0, 3'(vzoom_q), 2'h0, autorestart_q, autorange_q};
				SBC_REG_ITEMS:    rd_d = {22'h0, items_pend_q};
				SBC_REG_BPULSES:  rd_d = {15'h0, bpulse_pend_q};
				SBC_REG_BTIME:    rd_d = {15'h0, btime_pend_q};
				SBC_REG_SUBPULSE: rd_d = {15'h0, sub_pend_q};
				SBC_REG_RATEDIV:  rd_d = {28'h0, div_pend_q};
				SBC_REG_PSTIME:   rd_d = {15'h0, ps_pend_q};
				SBC_REG_STATUS:   rd_d = {30'h0, cycle_q, batch_q};
				SBC_REG_IRQ_STAT: rd_d = {28'h0, ev_stat_q};
				SBC_REG_IRQ_MASK: rd_d = {28'h0, ev_mask_q};
				SBC_REG_ITEMLIST: rd_d = {22'h0, items_shown};
				default:          rd_d = '0;
			endcase
		end
	end

	a_arg_keep: assert property (@(posedge mclk) disable iff (!rstn)
		(arg_err && req.adr == SBC_REG_BPULSES) |=> $stable(bpulse_pend_q) && ev_stat_q[SBC_EV_ARG_ERR])
		else $error("bad argument changed setting");

	a_list_err: assert property (@(posedge mclk) disable iff (!rstn)
		(wr && req.adr == SBC_REG_ITEMS && req.dat[31:16] > 16'h000a) |=> ev_stat_q[SBC_EV_LIST_ERR] && $stable(items_pend_q))
		else $error("long item list not flagged");

	a_six_shown: assert property (@(posedge mclk) disable iff (!rstn)
		$countones(items_shown) <= SBC_ITEMS_SHOWN && (items_shown & ~items_act_q) == '0)
		else $error("too many items shown");

	a_defer_apply: assert property (@(posedge mclk) disable iff (!rstn)
		(batch_q && !batch_end) |=> $stable(bpulse_act_q) && $stable(items_act_q))
		else $error("batch setting changed mid-batch");

	a_manual_stop: assert property (@(posedge mclk) disable iff (!rstn)
		(batch_end && !autorestart_q && cmd == '0) |=> !batch_q)
		else $error("manual batch restarted");

	a_start_gate: assert property (@(posedge mclk) disable iff (!rstn)
		(cmd[SBC_CMD_STAT_BEGIN] && env_q.stat_mode) |=> batch_q ##0 bcnt_q == '0)
		else $error("batch start not taken");

	a_stop_end: assert property (@(posedge mclk) disable iff (!rstn)
		(cmd[SBC_CMD_STAT_END] && !cmd[SBC_CMD_STAT_BEGIN] && env_q.stat_mode && batch_q) |=> !batch_q)
		else $error("batch stop ignored");

	a_cycle_stop: assert property (@(posedge mclk) disable iff (!rstn)
		(cmd[SBC_CMD_PS_END] && !cmd[SBC_CMD_PS_BEGIN] && env_q.ps_mode && cycle_q) |=> !cycle_q)
		else $error("cycle stop ignored");

	a_erase_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		cmd[SBC_CMD_TUNE_ERASE] |=> chart_erase_o ##1 !chart_erase_o || cmd[SBC_CMD_TUNE_ERASE])
		else $error("erase pulse missing");

endmodule : sbc_ctrl

//--- sbc_host.sv
// Host model: classic Wishbone master that issues the register commands.
// Assumes one clock, a slave that acks once per request, sel always full.
`timescale 1ns/1ps
module sbc_host
	import sbc_pkg::*;
(
	input  wire logic        mclk,
	output sbc_wb_req_type   req,
	output logic             cyc,
	output logic             stb,
	input  wire logic        ack,
	input  wire logic [31:0] dat
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		req = '0;
	end

	// Held until ack is sampled; bus then shows inverted junk
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		req <= '{adr: a, we: w, sel: 4'hf, dat: d};
		do @(posedge mclk); while (ack !== 1'b1);
		q = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		req <= sbc_wb_req_type'(~{a, w, 4'hf, d});
	endtask : xfer
endmodule : sbc_host

//--- test_stats_batch_cycle_control.sv
// Self-checking bench for the statistics batch and cycle control block.
// Assumes the host model above; tick shortened to 10 clocks per tick.
`timescale 1ns/1ps
module test_stats_batch_cycle_control;
	import sbc_pkg::*;
	logic           mclk;
	logic           rstn;
	sbc_wb_req_type req;
	logic           cyc;
	logic           stb;
	logic           ack;
	logic [31:0]    rdat;
	sbc_env_type    env;
	logic           pulse;
	logic           auto_range;
	logic [9:0]     shown;
	logic           batch_run;
	logic           sample;
	logic           cycle_run;
	sbc_zoom_type   vzoom;
	sbc_zoom_type   hzoom;
	logic           erase;
	logic           irq;
	int             n_mismatch = 0;
	int             num_checks = 0;
	int             n_sample = 0;
	int             n_erase = 0;

	sbc_ctrl #(.TICK_CYCLES(10)) sbc_ctrl_i (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .env_i(env), .pulse_i(pulse), .auto_range_o(auto_range), .items_shown_o(shown),
		.batch_run_o(batch_run), .sample_o(sample), .cycle_run_o(cycle_run), .vzoom_o(vzoom),
		.hzoom_o(hzoom), .chart_erase_o(erase), .irq_o(irq));
	sbc_host sbc_host_i (.mclk(mclk), .req(req), .cyc(cyc), .stb(stb), .ack(ack), .dat(rdat));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (sample === 1'b1) n_sample++;
		if (erase === 1'b1) n_erase++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		sbc_host_i.xfer(a, 1'b1, d, q);
	endtask : wr

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		sbc_host_i.xfer(a, 1'b0, 32'h0, q);
		check(q & m, exp);
	endtask : rdm

	task automatic cyc_wait(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc_wait

	task automatic give_pulses(input int n);
		repeat (n) begin
			pulse <= 1'b1;
			cyc_wait(4);
			pulse <= 1'b0;
			cyc_wait(4);
		end
		cyc_wait(4);
	endtask : give_pulses

	task automatic t_reset();
		check(auto_range, 1'b0);
		check(vzoom, SBC_ZOOM_AUTO);
		check(hzoom, SBC_ZOOM_X1);
		check(shown, SBC_ITEMS_RST);
		rdm(SBC_REG_BPULSES, 32'h1ffff, 32'd100);
		rdm(SBC_REG_BTIME, 32'h1ffff, 32'd60);
		rdm(SBC_REG_SUBPULSE, 32'h1ffff, 32'd1);
		rdm(SBC_REG_RATEDIV, 32'hf, 32'd1);
		rdm(SBC_REG_PSTIME, 32'h1ffff, 32'd60);
	endtask : t_reset

	task automatic t_range();
		wr(SBC_REG_IRQ_MASK, 32'h0);
		wr(SBC_REG_BPULSES, 32'd1);
		rdm(SBC_REG_BPULSES, 32'h1ffff, 32'd100);
		rdm(SBC_REG_IRQ_STAT, 32'h1, 32'h1);
		check(irq, 1'b0);
		wr(SBC_REG_IRQ_MASK, 32'h1);
		cyc_wait(2);
		check(irq, 1'b1);
		wr(SBC_REG_IRQ_STAT, 32'hf);
		cyc_wait(2);
		check(irq, 1'b0);
		wr(SBC_REG_BPULSES, 32'd99999);
		rdm(SBC_REG_BPULSES, 32'h1ffff, 32'd99999);
		wr(SBC_REG_BTIME, 32'd86401);
		rdm(SBC_REG_BTIME, 32'h1ffff, 32'd60);
		wr(SBC_REG_RATEDIV, 32'd3);
		rdm(SBC_REG_RATEDIV, 32'hf, 32'd1);
		wr(SBC_REG_SUBPULSE, 32'd0);
		rdm(SBC_REG_SUBPULSE, 32'h1ffff, 32'd1);
		wr(SBC_REG_IRQ_STAT, 32'hf);
	endtask : t_range

	task automatic t_items();
		// Host sends the list length with the mask, so eleven is too many
		wr(SBC_REG_ITEMS, {16'd11, 6'h0, 10'h3ff});
		rdm(SBC_REG_IRQ_STAT, 32'h8, 32'h8);
		check(shown, SBC_ITEMS_RST);
		wr(SBC_REG_ITEMS, {16'd10, 6'h0, 10'h3ff});
		cyc_wait(2);
		check(shown, 10'h03f);
		rdm(SBC_REG_ITEMS, 32'h3ff, 32'h3ff);
		wr(SBC_REG_IRQ_STAT, 32'hf);
	endtask : t_items

	task automatic t_batch();
		wr(SBC_REG_BPULSES, 32'd2);
		wr(SBC_REG_SUBPULSE, 32'd2);
		wr(SBC_REG_CMD, 32'h1);
		cyc_wait(3);
		check(batch_run, 1'b0);
		env.stat_mode <= 1'b1;
		env.pulse_sensor <= 1'b1;
		cyc_wait(4);
		wr(SBC_REG_CMD, 32'h1);
		cyc_wait(2);
		check(batch_run, 1'b1);
		wr(SBC_REG_ITEMS, {16'd1, 6'h0, 10'h001});
		n_sample = 0;
		give_pulses(3);
		check(shown, 10'h03f);
		check(batch_run, 1'b1);
		give_pulses(1);
		check(n_sample, 2);
		check(batch_run, 1'b0);
		check(shown, 10'h001);
		rdm(SBC_REG_IRQ_STAT, 32'h2, 32'h2);
		wr(SBC_REG_SUBPULSE, 32'd1);
		wr(SBC_REG_CMD, 32'h1);
		give_pulses(1);
		wr(SBC_REG_CMD, 32'h1);
		give_pulses(1);
		check(batch_run, 1'b1);
		env.range_sensor <= 1'b1;
		wr(SBC_REG_CTRL, 32'h103);
		// First pulse ends a batch; the restarted one needs two more
		give_pulses(1);
		wr(SBC_REG_IRQ_STAT, 32'h2);
		give_pulses(1);
		rdm(SBC_REG_IRQ_STAT, 32'h2, 32'h0);
		give_pulses(1);
		rdm(SBC_REG_IRQ_STAT, 32'h2, 32'h2);
		check(auto_range, 1'b1);
		check(batch_run, 1'b1);
		wr(SBC_REG_CMD, 32'h2);
		cyc_wait(2);
		check(batch_run, 1'b0);
		env.stat_mode <= 1'b0;
		env.range_sensor <= 1'b0;
		wr(SBC_REG_CTRL, 32'h100);
		wr(SBC_REG_IRQ_STAT, 32'hf);
	endtask : t_batch

	task automatic t_timed();
		int n;
		env.stat_mode <= 1'b1;
		env.pulse_sensor <= 1'b0;
		wr(SBC_REG_BTIME, 32'd1);
		wr(SBC_REG_RATEDIV, 32'd5);
		n_sample = 0;
		wr(SBC_REG_CMD, 32'h1);
		n = 0;
		while (batch_run !== 1'b0 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		// One second at two samples per second
		check(n_sample, 2);
		check(n >= 85 && n <= 115, 1'b1);
		rdm(SBC_REG_RATEDIV, 32'hf, 32'd5);
		env.stat_mode <= 1'b0;
		wr(SBC_REG_IRQ_STAT, 32'hf);
	endtask : t_timed

	task automatic t_cycle();
		int n;
		env.quad_sensor <= 1'b1;
		wr(SBC_REG_PSTIME, 32'd1);
		wr(SBC_REG_CMD, 32'h4);
		cyc_wait(3);
		check(cycle_run, 1'b0);
		env.ps_mode <= 1'b1;
		cyc_wait(4);
		// Cycles run on after their end, so watch the done event
		wr(SBC_REG_IRQ_MASK, 32'h4);
		wr(SBC_REG_CMD, 32'h4);
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		// One second is ten ticks of ten clocks
		check(n >= 85 && n <= 115, 1'b1);
		rdm(SBC_REG_IRQ_STAT, 32'h4, 32'h4);
		wr(SBC_REG_PSTIME, 32'd86400);
		wr(SBC_REG_CMD, 32'h4);
		env.ps_mode <= 1'b0;
		cyc_wait(4);
		wr(SBC_REG_CMD, 32'h8);
		cyc_wait(2);
		check(cycle_run, 1'b1);
		env.ps_mode <= 1'b1;
		cyc_wait(4);
		wr(SBC_REG_CMD, 32'h8);
		cyc_wait(2);
		check(cycle_run, 1'b0);
	endtask : t_cycle

	task automatic t_zoom();
		for (int i = 0; i < 6; i++) begin
			wr(SBC_REG_CTRL, (i << 4) | (i << 8));
			cyc_wait(1);
			check(vzoom, i);
			if (i > 0) check(hzoom, i);
		end
		// Horizontal auto is refused, so the whole write is dropped
		wr(SBC_REG_CTRL, 32'h020);
		cyc_wait(1);
		check(vzoom, SBC_ZOOM_X20);
		check(hzoom, SBC_ZOOM_X20);
		wr(SBC_REG_CMD, 32'h10);
		cyc_wait(3);
		check(n_erase, 1);
	endtask : t_zoom

	task automatic end_of_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	initial begin
		rstn = 1'b0;
		env = '0;
		pulse = 1'b0;
		cyc_wait(2);
		rstn <= 1'b1;
		t_reset();
		t_range();
		t_items();
		t_batch();
		t_timed();
		t_cycle();
		t_zoom();
		end_of_test();
	end

	initial begin
		cyc_wait(20000);
		n_mismatch++;
		end_of_test();
	end
endmodule : test_stats_batch_cycle_control
